// ==== rtl/mrf_consts.svh ====
`ifndef MRF_CONSTS_SVH
`define MRF_CONSTS_SVH

`define MRF_CLK_HZ 10000000
`define MRF_BAUD 9600
`define MRF_BITS_PER_CHAR 11
// one character slot, rounded up to whole cycles
`define MRF_CHAR_CYC ((`MRF_CLK_HZ * `MRF_BITS_PER_CHAR + `MRF_BAUD - 1) / `MRF_BAUD)
`define MRF_GAP_MIN_US 4000
`define MRF_GAP_MIN_CYC (`MRF_GAP_MIN_US * (`MRF_CLK_HZ / 1000000))
// 3.5 characters, rounded up
`define MRF_GAP_CHAR_CYC ((7 * `MRF_CHAR_CYC + 1) / 2)
`define MRF_GAP_CYC ((`MRF_GAP_CHAR_CYC > `MRF_GAP_MIN_CYC) ? `MRF_GAP_CHAR_CYC : `MRF_GAP_MIN_CYC)
`define MRF_RESP_TMO_CYC 200000

`define MRF_CRC_INIT 16'hFFFF
`define MRF_CRC_POLY 16'hA001

`define MRF_FC_RD_HOLD 8'h03
`define MRF_FC_RD_INPUT 8'h04
`define MRF_FC_WR_MULTI 8'h10

`define MRF_MAX_FRAME 7'h68
`define MRF_MAX_RD_QTY 16'h0031
`define MRF_MAX_WR_QTY 16'h002F

`define MRF_REG_ERR_LIST 16'h021A
`define MRF_REG_ERR_CNT 16'h021B
`define MRF_REG_BATT_LOW 16'h022A
`define MRF_REG_BLOCKED 16'h022B
`define MRF_REG_ROCKER 16'h03FE
`define MRF_ERR_CNT_RESET 16'h0000
`define MRF_HOLD_BASE 16'h0010
`define MRF_HOLD_NUM 16'h0004

`define MRF_CR_CTRL 4'h0
`define MRF_CR_SLAVE 4'h1
`define MRF_CR_FUNC 4'h2
`define MRF_CR_START 4'h3
`define MRF_CR_QTY 4'h4
`define MRF_CR_WDATA0 4'h8
`define MRF_CR_RDATA0 4'hC

`endif

// ==== rtl/mrf_pkg.sv ====
`include "mrf_consts.svh"

package mrf_pkg;

  typedef enum logic [1:0] {
    MRF_D_IDLE = 2'b00,
    MRF_D_WRITE = 2'b01,
    MRF_D_REPLY = 2'b10,
    MRF_D_DRAIN = 2'b11
  } mrf_dev_state_t;

  typedef enum logic [2:0] {
    MRF_M_IDLE = 3'b000,
    MRF_M_GAP = 3'b001,
    MRF_M_SEND = 3'b010,
    MRF_M_WAIT = 3'b011,
    MRF_M_RECV = 3'b100
  } mrf_mst_state_t;

  function automatic logic [15:0] mrf_crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `MRF_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : mrf_crc_byte

endpackage : mrf_pkg

// ==== rtl/mrf_link_if.sv ====
`timescale 1ns/10ps

// one character per valid pulse; senders pace pulses one character slot apart
interface mrf_link_if;
  logic m2s_valid;
  logic [7:0] m2s_data;
  logic s2m_valid;
  logic [7:0] s2m_data;

  modport dev (input m2s_valid, input m2s_data, output s2m_valid, output s2m_data);
  modport mst (output m2s_valid, output m2s_data, input s2m_valid, input s2m_data);
endinterface : mrf_link_if

// ==== rtl/mrf_master_end.sv ====
`timescale 1ns/10ps
`include "mrf_consts.svh"

module mrf_master_end #(
  parameter int CHAR_CYC = `MRF_CHAR_CYC,
  parameter int GAP_CYC = `MRF_GAP_CYC,
  parameter int TMO_CYC = `MRF_RESP_TMO_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  mrf_link_if.mst link,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [15:0] rdata_o
);
  mrf_pkg::mrf_mst_state_t st_q;
  logic [7:0] slave_q, func_q;
  logic [15:0] start_q;
  logic [2:0] qty_q;
  logic [15:0] wd_q [0:3];
  logic [15:0] rd_q [0:3];
  logic busy_q, ok_q, err_q;
  logic [15:0] sil_q, pace_q, crc_q;
  logic [19:0] tmo_q;
  logic [7:0] tidx_q, tlen, tbyte, toff, ridx_q, roff;
  logic [7:0] r0_q, r1_q;
  logic m2s_valid_q;
  logic [7:0] m2s_data_q;
  logic [15:0] rdata_q;
  logic go, send, gap_hit, reply_ok;

  assign link.m2s_valid = m2s_valid_q;
  assign link.m2s_data = m2s_data_q;
  assign rdata_o = rdata_q;
  assign go = we_i && addr_i == `MRF_CR_CTRL && wdata_i[0] && !busy_q;
  assign send = st_q == mrf_pkg::MRF_M_SEND && pace_q == 16'h0000;
  assign gap_hit = sil_q == 16'(GAP_CYC);
  assign tlen = (func_q == `MRF_FC_WR_MULTI) ? 8'(9 + 2 * qty_q) : 8'h08;
  assign toff = tidx_q - 8'h07;
  assign roff = ridx_q - 8'h03;

  always_comb begin
    case (tidx_q)
      8'h00: tbyte = slave_q;
      8'h01: tbyte = func_q;
      8'h02: tbyte = start_q[15:8];
      8'h03: tbyte = start_q[7:0];
      8'h04: tbyte = 8'h00;
      8'h05: tbyte = {5'h00, qty_q};
      8'h06: tbyte = {4'h0, qty_q, 1'b0};
      default: tbyte = toff[0] ? wd_q[toff[2:1]][7:0] : wd_q[toff[2:1]][15:8];
    endcase
    if (tidx_q == tlen - 8'h02) tbyte = crc_q[7:0];
    if (tidx_q == tlen - 8'h01) tbyte = crc_q[15:8];
  end

  // software register port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slave_q <= 8'h01;
      func_q <= `MRF_FC_RD_INPUT;
      start_q <= 16'h0000;
      qty_q <= 3'h1;
      for (int i = 0; i < 4; i++) wd_q[i] <= 16'h0000;
    end else if (we_i && !busy_q) begin
      case (addr_i)
        `MRF_CR_SLAVE: slave_q <= wdata_i[7:0];
        `MRF_CR_FUNC: func_q <= wdata_i[7:0];
        `MRF_CR_START: start_q <= wdata_i;
        `MRF_CR_QTY: qty_q <= wdata_i[2:0];
        default: if (addr_i[3:2] == 2'b10) wd_q[addr_i[1:0]] <= wdata_i;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) rdata_q <= 16'h0000;
    else if (re_i) begin
      case (addr_i)
        `MRF_CR_CTRL: rdata_q <= {13'h0000, err_q, ok_q, busy_q};
        `MRF_CR_SLAVE: rdata_q <= {8'h00, slave_q};
        `MRF_CR_FUNC: rdata_q <= {8'h00, func_q};
        `MRF_CR_START: rdata_q <= start_q;
        `MRF_CR_QTY: rdata_q <= {13'h0000, qty_q};
        default: rdata_q <= addr_i[3] ? (addr_i[2] ? rd_q[addr_i[1:0]] : wd_q[addr_i[1:0]])
                                     : 16'h0000;
      endcase
    end
  end

  // silence since the last character in either direction
  always_ff @(posedge clk_i) begin
    if (rst_i) sil_q <= 16'h0000;
    else if (link.s2m_valid || m2s_valid_q) sil_q <= 16'h0000;
    else if (!gap_hit) sil_q <= sil_q + 16'h0001;
  end

  assign reply_ok = crc_q == 16'h0000 && r0_q == slave_q && r1_q == func_q
    && ridx_q == ((func_q == `MRF_FC_WR_MULTI) ? 8'h08 : 8'(5 + 2 * qty_q));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= mrf_pkg::MRF_M_IDLE;
      busy_q <= 1'b0;
      ok_q <= 1'b0;
      err_q <= 1'b0;
      tidx_q <= 8'h00;
      ridx_q <= 8'h00;
      pace_q <= 16'h0000;
      tmo_q <= 20'h00000;
      crc_q <= `MRF_CRC_INIT;
      m2s_valid_q <= 1'b0;
      m2s_data_q <= 8'h00;
      r0_q <= 8'h00;
      r1_q <= 8'h00;
      for (int i = 0; i < 4; i++) rd_q[i] <= 16'h0000;
    end else begin
      m2s_valid_q <= send;
      if (pace_q != 16'h0000) pace_q <= pace_q - 16'h0001;
      case (st_q)
        mrf_pkg::MRF_M_IDLE: if (go) begin
          busy_q <= 1'b1;
          ok_q <= 1'b0;
          err_q <= 1'b0;
          tidx_q <= 8'h00;
          crc_q <= `MRF_CRC_INIT;
          if (qty_q == 3'h0 || qty_q > 3'h4) begin
            busy_q <= 1'b0;
            err_q <= 1'b1;
          end else st_q <= mrf_pkg::MRF_M_GAP;
        end
        mrf_pkg::MRF_M_GAP: if (gap_hit) st_q <= mrf_pkg::MRF_M_SEND;
        mrf_pkg::MRF_M_SEND: if (send) begin
          m2s_data_q <= tbyte;
          pace_q <= 16'(CHAR_CYC - 1);
          tidx_q <= tidx_q + 8'h01;
          if (tidx_q < tlen - 8'h02) crc_q <= mrf_pkg::mrf_crc_byte(crc_q, tbyte);
          if (tidx_q == tlen - 8'h01) begin
            st_q <= mrf_pkg::MRF_M_WAIT;
            tmo_q <= 20'(TMO_CYC);
            crc_q <= `MRF_CRC_INIT;
            ridx_q <= 8'h00;
          end
        end
        mrf_pkg::MRF_M_WAIT: begin
          tmo_q <= tmo_q - 20'h00001;
          if (link.s2m_valid) st_q <= mrf_pkg::MRF_M_RECV;
          else if (tmo_q == 20'h00000) begin
            st_q <= mrf_pkg::MRF_M_IDLE;
            busy_q <= 1'b0;
            err_q <= 1'b1;
          end
        end
        mrf_pkg::MRF_M_RECV: if (gap_hit) begin
          st_q <= mrf_pkg::MRF_M_IDLE;
          busy_q <= 1'b0;
          ok_q <= reply_ok;
          err_q <= !reply_ok;
        end
        default: st_q <= mrf_pkg::MRF_M_IDLE;
      endcase
      if (link.s2m_valid && (st_q == mrf_pkg::MRF_M_WAIT || st_q == mrf_pkg::MRF_M_RECV)) begin
        crc_q <= mrf_pkg::mrf_crc_byte(crc_q, link.s2m_data);
        if (ridx_q != 8'hFF) ridx_q <= ridx_q + 8'h01;
        if (ridx_q == 8'h00) r0_q <= link.s2m_data;
        if (ridx_q == 8'h01) r1_q <= link.s2m_data;
        if (func_q != `MRF_FC_WR_MULTI && ridx_q >= 8'h03 && roff < 8'h08) begin
          if (roff[0]) rd_q[roff[2:1]][7:0] <= link.s2m_data;
          else rd_q[roff[2:1]][15:8] <= link.s2m_data;
        end
      end
    end
  end
endmodule : mrf_master_end

// ==== rtl/mrf_slave_end.sv ====
`timescale 1ns/10ps
`include "mrf_consts.svh"

// Behaviour
// - execute only read-hold, read-input, write-multiple
// - transmit only replies to addressed requests
// - master alone starts every exchange
// - order address, function, data, checksum
// - gap of 3.5 characters between telegrams
// - gap at least 4 ms at 9600
// - one address byte, data 0-100 bytes
// - sender appends CRC over preceding bytes
// - receiver discards telegram on CRC mismatch
// - CRC low byte first, high last
// - CRC init FFFF, reflected poly A001
// - battery low bits, channel per bit
// - obstruction bits, channel per bit
// - error word channel, type, pending bit
// - rocker buttons in bits 4 to 7
module mrf_slave_end #(
  parameter int CHAR_CYC = `MRF_CHAR_CYC,
  parameter int GAP_CYC = `MRF_GAP_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  mrf_link_if.dev link,
  input wire logic [7:0] slave_addr_i,
  input wire logic [5:0] batt_low_i,
  input wire logic [5:0] blocked_i,
  input wire logic [7:0] err_chan_i,
  input wire logic [6:0] err_type_i,
  input wire logic err_pend_i,
  input wire logic err_event_i,
  input wire logic [3:0] rocker_i,
  output logic [63:0] hold_o,
  output logic busy_o
);
  mrf_pkg::mrf_dev_state_t st_q;
  logic [7:0] rx_buf [0:103];
  logic [6:0] rx_cnt_q;
  logic rx_ovf_q;
  logic [15:0] rx_crc_q, sil_q;
  logic frame_end, rd_ok, wr_ok, frame_ok, rx_take;
  logic [15:0] rq_start, rq_qty;

  logic [7:0] func_q;
  logic [15:0] start_q;
  logic [6:0] qty_q, widx_q;
  logic [7:0] tidx_q, tlen_q, toff, tbyte;
  logic [15:0] tcrc_q, waddr, wsel, wword, err_cnt_q;
  logic [15:0] hold_q [0:3];
  logic [15:0] hidx, whidx;

  logic [7:0] fifo_q [0:1];
  logic wp_q, rp_q;
  logic [1:0] fcnt_q;
  logic push, pop;
  logic [15:0] pace_q;
  logic s2m_valid_q, busy_q;
  logic [7:0] s2m_data_q;

  assign link.s2m_valid = s2m_valid_q;
  assign link.s2m_data = s2m_data_q;
  assign busy_o = busy_q;
  assign hold_o = {hold_q[3], hold_q[2], hold_q[1], hold_q[0]};

  // receive assembly; requests arriving while busy are dropped (half duplex)
  assign rx_take = link.m2s_valid && st_q == mrf_pkg::MRF_D_IDLE;
  assign frame_end = sil_q == 16'(GAP_CYC - 1) && !link.m2s_valid && rx_cnt_q != 7'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) sil_q <= 16'h0000;
    else if (link.m2s_valid) sil_q <= 16'h0000;
    else if (sil_q != 16'(GAP_CYC)) sil_q <= sil_q + 16'h0001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_cnt_q <= 7'h00;
      rx_ovf_q <= 1'b0;
      rx_crc_q <= `MRF_CRC_INIT;
    end else if (rx_take) begin
      if (rx_cnt_q == `MRF_MAX_FRAME) rx_ovf_q <= 1'b1;
      else begin
        rx_buf[rx_cnt_q] <= link.m2s_data;
        rx_cnt_q <= rx_cnt_q + 7'h01;
      end
      rx_crc_q <= mrf_pkg::mrf_crc_byte(rx_crc_q, link.m2s_data);
    end else if (frame_end) begin
      rx_cnt_q <= 7'h00;
      rx_ovf_q <= 1'b0;
      rx_crc_q <= `MRF_CRC_INIT;
    end
  end

  // crc over the whole frame including its checksum leaves zero when intact
  assign rq_start = {rx_buf[2], rx_buf[3]};
  assign rq_qty = {rx_buf[4], rx_buf[5]};
  assign rd_ok = (rx_buf[1] == `MRF_FC_RD_HOLD || rx_buf[1] == `MRF_FC_RD_INPUT)
    && rx_cnt_q == 7'h08 && rq_qty != 16'h0000 && rq_qty <= `MRF_MAX_RD_QTY;
  assign wr_ok = rx_buf[1] == `MRF_FC_WR_MULTI && rq_qty != 16'h0000
    && rq_qty <= `MRF_MAX_WR_QTY && rx_buf[6] == {rq_qty[6:0], 1'b0}
    && rx_cnt_q == 7'(9 + 2 * rq_qty[6:0]);
  assign frame_ok = frame_end && !rx_ovf_q && rx_cnt_q >= 7'h04
    && rx_crc_q == 16'h0000
    && rx_buf[0] == slave_addr_i
    && (rd_ok || wr_ok);

  assign toff = tidx_q - 8'h03;
  assign wsel = start_q + {9'h000, toff[7:1]};
  assign hidx = wsel - `MRF_HOLD_BASE;
  assign waddr = start_q + {9'h000, widx_q};
  assign whidx = waddr - `MRF_HOLD_BASE;

  always_comb begin
    wword = 16'h0000;
    if (func_q == `MRF_FC_RD_HOLD) begin
      if (wsel >= `MRF_HOLD_BASE && wsel < `MRF_HOLD_BASE + `MRF_HOLD_NUM) wword = hold_q[hidx[1:0]];
    end else begin
      case (wsel)
        `MRF_REG_ERR_LIST: wword = {err_pend_i, err_type_i, err_chan_i};
        `MRF_REG_ERR_CNT: wword = err_cnt_q;
        `MRF_REG_BATT_LOW: wword = {10'h000, batt_low_i};
        `MRF_REG_BLOCKED: wword = {10'h000, blocked_i};
        `MRF_REG_ROCKER: wword = {8'h00, rocker_i, 4'h0};
        default: wword = 16'h0000;
      endcase
    end
  end

  always_comb begin
    case (tidx_q)
      8'h00: tbyte = slave_addr_i;
      8'h01: tbyte = func_q;
      default: begin
        if (func_q == `MRF_FC_WR_MULTI) begin
          case (tidx_q)
            8'h02: tbyte = start_q[15:8];
            8'h03: tbyte = start_q[7:0];
            8'h04: tbyte = 8'h00;
            default: tbyte = {1'b0, qty_q};
          endcase
        end else if (tidx_q == 8'h02) tbyte = {qty_q, 1'b0};
        else tbyte = toff[0] ? wword[7:0] : wword[15:8];
      end
    endcase
    if (tidx_q == tlen_q - 8'h02) tbyte = tcrc_q[7:0];
    if (tidx_q == tlen_q - 8'h01) tbyte = tcrc_q[15:8];
  end

  assign push = st_q == mrf_pkg::MRF_D_REPLY && fcnt_q != 2'h2;
  assign pop = fcnt_q != 2'h0 && pace_q == 16'h0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= mrf_pkg::MRF_D_IDLE;
      func_q <= 8'h00;
      start_q <= 16'h0000;
      qty_q <= 7'h00;
      widx_q <= 7'h00;
      tidx_q <= 8'h00;
      tlen_q <= 8'h00;
      tcrc_q <= `MRF_CRC_INIT;
      busy_q <= 1'b0;
    end else begin
      busy_q <= st_q != mrf_pkg::MRF_D_IDLE;
      case (st_q)
        mrf_pkg::MRF_D_IDLE: if (frame_ok) begin
          func_q <= rx_buf[1];
          start_q <= rq_start;
          qty_q <= rq_qty[6:0];
          widx_q <= 7'h00;
          tidx_q <= 8'h00;
          tcrc_q <= `MRF_CRC_INIT;
          tlen_q <= wr_ok ? 8'h08 : 8'(5 + 2 * rq_qty[6:0]);
          st_q <= wr_ok ? mrf_pkg::MRF_D_WRITE : mrf_pkg::MRF_D_REPLY;
        end
        mrf_pkg::MRF_D_WRITE: begin
          widx_q <= widx_q + 7'h01;
          if (widx_q == qty_q - 7'h01) st_q <= mrf_pkg::MRF_D_REPLY;
        end
        mrf_pkg::MRF_D_REPLY: if (push) begin
          tidx_q <= tidx_q + 8'h01;
          if (tidx_q < tlen_q - 8'h02) tcrc_q <= mrf_pkg::mrf_crc_byte(tcrc_q, tbyte);
          if (tidx_q == tlen_q - 8'h01) st_q <= mrf_pkg::MRF_D_DRAIN;
        end
        mrf_pkg::MRF_D_DRAIN: if (fcnt_q == 2'h0 && pace_q == 16'h0000) begin
          st_q <= mrf_pkg::MRF_D_IDLE;
        end
        default: st_q <= mrf_pkg::MRF_D_IDLE;
      endcase
    end
  end

  // holding words; addresses outside the block are skipped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 4; i++) hold_q[i] <= 16'h0000;
    end else if (st_q == mrf_pkg::MRF_D_WRITE
                 && waddr >= `MRF_HOLD_BASE && waddr < `MRF_HOLD_BASE + `MRF_HOLD_NUM) begin
      hold_q[whidx[1:0]] <= {rx_buf[7'(7 + 2 * widx_q)], rx_buf[7'(8 + 2 * widx_q)]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) err_cnt_q <= `MRF_ERR_CNT_RESET;
    else if (err_event_i && err_cnt_q != 16'hFFFF) err_cnt_q <= err_cnt_q + 16'h0001;
  end

  // two-entry buffer: the generator stalls while the character pacer drains
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      fcnt_q <= 2'h0;
    end else begin
      if (push) begin
        fifo_q[wp_q] <= tbyte;
        wp_q <= !wp_q;
      end
      if (pop) rp_q <= !rp_q;
      fcnt_q <= fcnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pace_q <= 16'h0000;
      s2m_valid_q <= 1'b0;
      s2m_data_q <= 8'h00;
    end else begin
      s2m_valid_q <= pop;
      if (pop) begin
        s2m_data_q <= fifo_q[rp_q];
        pace_q <= 16'(CHAR_CYC - 1);
      end else if (pace_q != 16'h0000) pace_q <= pace_q - 16'h0001;
    end
  end
endmodule : mrf_slave_end

// ==== verif/mrf_link_properties.sv ====
`timescale 1ns/10ps

module mrf_link_properties #(
  parameter int CHAR_CYC = 8,
  parameter int GAP_CYC = 40
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic m2s_valid,
  input wire logic [7:0] m2s_data,
  input wire logic s2m_valid,
  input wire logic [7:0] s2m_data
);
  // silence counters saturate high so the first frame after reset counts as a new one
  logic [9:0] m_sil_q, s_sil_q;
  logic [7:0] m_cnt_q, s_cnt_q;
  logic [15:0] m_crc_q, s_crc_q;
  logic m_new, s_new, m_end, s_end;

  function automatic logic [15:0] step_crc(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
    end
    return r;
  endfunction : step_crc

  assign m_new = m_sil_q > 10'(2 * CHAR_CYC);
  assign s_new = s_sil_q > 10'(2 * CHAR_CYC);
  assign m_end = m_sil_q == 10'(2 * CHAR_CYC) && m_cnt_q != 8'h00;
  assign s_end = s_sil_q == 10'(2 * CHAR_CYC) && s_cnt_q != 8'h00;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m_sil_q <= 10'h3FF;
      m_cnt_q <= 8'h00;
      m_crc_q <= 16'hFFFF;
    end else if (m2s_valid) begin
      m_sil_q <= 10'h000;
      m_cnt_q <= m_new ? 8'h01 : m_cnt_q + 8'h01;
      m_crc_q <= step_crc(m_new ? 16'hFFFF : m_crc_q, m2s_data);
    end else if (m_sil_q != 10'h3FF) begin
      m_sil_q <= m_sil_q + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_sil_q <= 10'h3FF;
      s_cnt_q <= 8'h00;
      s_crc_q <= 16'hFFFF;
    end else if (s2m_valid) begin
      s_sil_q <= 10'h000;
      s_cnt_q <= s_new ? 8'h01 : s_cnt_q + 8'h01;
      s_crc_q <= step_crc(s_new ? 16'hFFFF : s_crc_q, s2m_data);
    end else if (s_sil_q != 10'h3FF) begin
      s_sil_q <= s_sil_q + 10'h001;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  m2s_spacing_a: assert property (m2s_valid |-> m_sil_q >= 10'(CHAR_CYC - 1))
    else $error("master characters too close");
  s2m_spacing_a: assert property (s2m_valid |-> s_sil_q >= 10'(CHAR_CYC - 1))
    else $error("slave characters too close");
  master_gap_a: assert property (m2s_valid && m_new |->
    m_sil_q >= 10'(GAP_CYC - 2) && s_sil_q >= 10'(GAP_CYC - 2))
    else $error("request started without inter-telegram gap");
  reply_window_a: assert property (s2m_valid && s_new |->
    m_sil_q >= 10'(GAP_CYC - 1) && m_sil_q <= 10'(GAP_CYC + 16))
    else $error("reply not tied to a finished request");
  m2s_crc_a: assert property (m_end |-> m_crc_q == 16'h0000)
    else $error("request checksum residue not zero");
  s2m_crc_a: assert property (s_end |-> s_crc_q == 16'h0000)
    else $error("reply checksum residue not zero");
  m2s_length_a: assert property (m_end |-> m_cnt_q >= 8'h04 && m_cnt_q <= 8'h68)
    else $error("request length out of range");
  s2m_length_a: assert property (s_end |-> s_cnt_q >= 8'h05 && s_cnt_q <= 8'h68)
    else $error("reply length out of range");
endmodule : mrf_link_properties

// ==== verif/modbus_rtu_slave_framer_bench.sv ====
`timescale 1ns/10ps

module modbus_rtu_slave_framer_bench;
  localparam int CC = 8;
  localparam int GC = 40;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [15:0] rdata_o;
  logic [7:0] slave_addr_i = 8'h01;
  logic [5:0] batt_low_i = 6'h25;
  logic [5:0] blocked_i = 6'h1A;
  logic [7:0] err_chan_i = 8'hA5;
  logic [6:0] err_type_i = 7'h5A;
  logic err_pend_i = 1'b1;
  logic err_event_i = 1'b0;
  logic [3:0] rocker_i = 4'h9;
  logic [63:0] hold_o;
  logic busy_o;
  int num_errors = 0;
  int checks_done = 0;
  logic [7:0] mq[$], sq[$], bq[$];
  // sampled while polling: tells an executed request from a dropped one
  logic busy_seen = 1'b0;

  mrf_link_if link_a ();
  mrf_link_if link_b ();
  mrf_master_end #(.CHAR_CYC(CC), .GAP_CYC(GC), .TMO_CYC(400)) mrf_master_end_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_a), .addr_i(addr_i), .wdata_i(wdata_i),
    .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o));
  mrf_slave_end #(.CHAR_CYC(CC), .GAP_CYC(GC)) mrf_slave_end_inst (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_a), .slave_addr_i(slave_addr_i),
    .batt_low_i(batt_low_i), .blocked_i(blocked_i), .err_chan_i(err_chan_i),
    .err_type_i(err_type_i), .err_pend_i(err_pend_i), .err_event_i(err_event_i),
    .rocker_i(rocker_i), .hold_o(hold_o), .busy_o(busy_o));
  // second slave faces the bench directly so it can be fed broken telegrams
  mrf_slave_end #(.CHAR_CYC(CC), .GAP_CYC(GC)) mrf_slave_end_inst_b (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_b), .slave_addr_i(slave_addr_i),
    .batt_low_i(batt_low_i), .blocked_i(blocked_i), .err_chan_i(err_chan_i),
    .err_type_i(err_type_i), .err_pend_i(err_pend_i), .err_event_i(err_event_i),
    .rocker_i(rocker_i), .hold_o(), .busy_o());
  mrf_link_properties #(.CHAR_CYC(CC), .GAP_CYC(GC)) mrf_link_properties_inst (
    .clk_i(clk_i), .rst_i(rst_i), .m2s_valid(link_a.m2s_valid), .m2s_data(link_a.m2s_data),
    .s2m_valid(link_a.s2m_valid), .s2m_data(link_a.s2m_data));

  always #50 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (link_a.m2s_valid === 1'b1) mq.push_back(link_a.m2s_data);
    if (link_a.s2m_valid === 1'b1) sq.push_back(link_a.s2m_data);
    if (link_b.s2m_valid === 1'b1) bq.push_back(link_b.s2m_data);
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] crc_of(input logic [7:0] q[$]);
    logic [15:0] r;
    r = 16'hFFFF;
    foreach (q[i]) begin
      r = r ^ {8'h00, q[i]};
      for (int k = 0; k < 8; k++) begin
        r = r[0] ? ((r >> 1) ^ 16'hA001) : (r >> 1);
      end
    end
    return r;
  endfunction : crc_of

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask : rd

  task automatic run(input logic [7:0] sa, input logic [7:0] fc, input logic [15:0] st,
      input logic [15:0] qty, output logic [15:0] stat);
    mq.delete();
    sq.delete();
    wr(4'h1, {8'h00, sa});
    wr(4'h2, {8'h00, fc});
    wr(4'h3, st);
    wr(4'h4, qty);
    wr(4'h0, 16'h0001);
    stat = 16'h0001;
    busy_seen = 1'b0;
    for (int i = 0; i < 2000 && stat[0] !== 1'b0; i++) begin
      rd(4'h0, stat);
      busy_seen = busy_seen | busy_o;
    end
    if (stat[0] !== 1'b0) begin
      check("master done", stat[0], 1'b0);
      stop_test();
    end
    check("req len", mq.size(), (fc == 8'h10) ? 9 + 2 * qty : 8);
    check("req addr", mq[0], sa);
    check("req func", mq[1], fc);
    check("req crc", crc_of(mq), 16'h0000);
    if (sq.size() > 1) begin
      check("rsp addr", sq[0], sa);
      check("rsp func", sq[1], fc);
      check("rsp crc", crc_of(sq), 16'h0000);
    end
  endtask : run

  task automatic t_inputs();
    logic [15:0] s, v, w;
    rd(4'h0, v);
    check("status reset", v, 16'h0000);
    check("busy idle", busy_o, 1'b0);
    run(8'h01, 8'h04, 16'h021B, 16'h0001, s);
    rd(4'hC, v);
    check("counter reset", v, 16'h0000);
    @(posedge clk_i);
    err_event_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    err_event_i <= 1'b0;
    run(8'h01, 8'h04, 16'h021A, 16'h0002, s);
    check("status", s[2:0], 3'b010);
    rd(4'hC, v);
    rd(4'hD, w);
    check("error word", v, 16'hDAA5);
    check("counter", w, 16'h0003);
    run(8'h01, 8'h04, 16'h022A, 16'h0002, s);
    rd(4'hC, v);
    rd(4'hD, w);
    check("battery", v, 16'h0025);
    check("blocked", w, 16'h001A);
    run(8'h01, 8'h04, 16'h03FE, 16'h0001, s);
    rd(4'hC, v);
    check("rocker", v, 16'h0090);
    $display("test inputs done");
  endtask : t_inputs

  task automatic t_hold();
    logic [15:0] s, v;
    logic [15:0] w[4] = '{16'h1234, 16'hABCD, 16'h0F0F, 16'h8001};
    for (int i = 0; i < 4; i++) wr(4'(8 + i), w[i]);
    run(8'h01, 8'h10, 16'h0010, 16'h0004, s);
    check("write status", s[2:0], 3'b010);
    check("write busy", busy_seen, 1'b1);
    check("write reply len", sq.size(), 8);
    check("hold", hold_o, {w[3], w[2], w[1], w[0]});
    run(8'h01, 8'h03, 16'h0010, 16'h0004, s);
    check("read reply len", sq.size(), 13);
    for (int i = 0; i < 4; i++) begin
      rd(4'(12 + i), v);
      check("hold readback", v, w[i]);
    end
    $display("test hold done");
  endtask : t_hold

  task automatic t_refuse();
    logic [15:0] s;
    logic [7:0] sa[3] = '{8'h22, 8'h01, 8'h22};
    logic [7:0] fc[3] = '{8'h04, 8'h06, 8'h10};
    for (int i = 0; i < 3; i++) begin
      wr(4'h8, 16'h5555);
      run(sa[i], fc[i], 16'h0010, 16'h0001, s);
      check("refused status", s[2:0], 3'b100);
      check("refused silent", sq.size(), 0);
      check("refused idle", busy_seen, 1'b0);
    end
    check("hold kept", hold_o[15:0], 16'h1234);
    $display("test refuse done");
  endtask : t_refuse

  task automatic send_b(input logic [7:0] q[$], input int n_exp);
    bq.delete();
    foreach (q[i]) begin
      @(posedge clk_i);
      link_b.m2s_valid <= 1'b1;
      link_b.m2s_data <= q[i];
      @(posedge clk_i);
      link_b.m2s_valid <= 1'b0;
      repeat (CC - 2) @(posedge clk_i);
    end
    // fixed window: absence of a reply can only be judged after it
    repeat (GC + 8 * CC + 80) @(posedge clk_i);
    check("reply count", bq.size(), n_exp);
  endtask : send_b

  task automatic t_crc();
    logic [7:0] q[$] = '{8'h01, 8'h04, 8'h02, 8'h2A, 8'h00, 8'h01};
    logic [7:0] b[$];
    logic [15:0] c;
    c = crc_of(q);
    b = {q, c[7:0], ~c[15:8]};
    send_b(b, 0);
    b = {q, c[15:8], c[7:0]};
    send_b(b, 0);
    b = {q, c[7:0], c[15:8]};
    send_b(b, 7);
    check("b addr", bq[0], 8'h01);
    check("b data", {bq[3], bq[4]}, 16'h0025);
    check("b crc", crc_of(bq), 16'h0000);
    $display("test crc done");
  endtask : t_crc

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test

  initial begin
    link_b.m2s_valid <= 1'b0;
    link_b.m2s_data <= 8'h00;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_inputs();
    t_hold();
    t_refuse();
    t_crc();
    stop_test();
  end
endmodule : modbus_rtu_slave_framer_bench
